/* File: rtl/dcc_pkg.sv */
// constants and types of the dual comparator control block
// Operation
// - comparator B result in bit 7, read-only
// - raw result high when positive above negative
// - bit 6 clear places result on pin
// - bit 5 clear inverts result, set passes
// - bit 4 picks A positive or B negative
// - bit 1 set picks B positive pin
// - bit 2 picks B negative pin or reference
// - bit 3 switches comparator B on
// - bit 0 clear enables wake on change
// - fields apply only while comparator is on
// - enabled output enable overrides timer pin direction
// - wake flag needs enable, sleep and change
// - control read latches both comparator states
// - wake flag cleared by software or reset
// - power-on loads all ones, others keep
package dcc_pkg;
	localparam logic [4:0] DCC_OFS_CMP_B = 5'h00;
	localparam logic [4:0] DCC_OFS_CMP_A = 5'h04;
	localparam logic [4:0] DCC_OFS_STATUS = 5'h08;
	localparam logic [4:0] DCC_OFS_IRQ_ST = 5'h0C;
	localparam logic [4:0] DCC_OFS_IRQ_MASK = 5'h10;
	localparam logic [7:0] DCC_CTRL_RESET = 8'hFF;
	localparam int DCC_BIT_RESULT = 7;
	localparam int DCC_BIT_PIN_N = 6;
	localparam int DCC_BIT_POL = 5;
	localparam int DCC_BIT_POS2 = 4;
	localparam int DCC_BIT_ON = 3;
	localparam int DCC_BIT_NEG = 2;
	localparam int DCC_BIT_POS1 = 1;
	localparam int DCC_BIT_WAKE_N = 0;
	localparam int DCC_BIT_WAKE_FLAG = 6;
	localparam int DCC_IRQ_W = 3;
	localparam int DCC_IRQ_WAKE = 0;
	localparam int DCC_IRQ_B_CHG = 1;
	localparam int DCC_IRQ_A_CHG = 2;
	// positive input choice of comparator B
	typedef enum logic [1:0] {
		DCC_POS_B_NEG_PIN = 2'h0,
		DCC_POS_A_POS_PIN = 2'h1,
		DCC_POS_B_POS_PIN = 2'h3
	} dcc_pos_e;
	typedef struct packed {
		logic on;
		dcc_pos_e pos_sel;
		logic neg_pin;
	} dcc_analog_s;
	typedef struct packed {
		logic out;
		logic oe;
	} dcc_pin_s;
	typedef struct packed {
		logic [7:0] cmp_b_ctl;
		logic [7:0] cmp_a_ctl;
		logic res_a;
		logic res_b;
		logic lat_a;
		logic lat_b;
		logic wake;
		logic [DCC_IRQ_W-1:0] irq_st;
		logic [DCC_IRQ_W-1:0] irq_mask;
		logic waitreq;
		logic [31:0] rdata;
		logic irq;
		dcc_analog_s ana_b;
		logic ana_a_on;
		dcc_pin_s pin_c4;
	} dcc_state_s;
endpackage

/* File: rtl/dcc_top.sv */
// comparator control registers, wake flag and pin steering
//
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module dcc_top
	import dcc_pkg::*;
#(
	parameter int ADDR_W = 5
) (
	input wire logic CLOCK,
	input wire logic SRST,
	input wire logic DEV_RST,
	input wire logic [ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	output logic IRQ,
	input wire logic CMP_A_RAW,
	input wire logic CMP_B_RAW,
	input wire logic SLEEP,
	input wire logic TIMER_CLOCK_SOURCE_SELECT,
	input wire logic PIN_DIRECTION_CONTROL_C4,
	input wire logic PORT_C_PIN_FOUR_DATA,
	output logic PORT_C_PIN_FOUR_OUT,
	output logic PORT_C_PIN_FOUR_OE,
	output logic CMP_B_ANALOG_ON,
	output logic [1:0] CMP_B_POS_SELECT,
	output logic CMP_B_NEG_SELECT,
	output logic CMP_A_ANALOG_ON
);
	// a narrower address cannot reach the upper registers
	if (ADDR_W < 5) begin
		$error("ADDR_W must be at least 5");
	end

	dcc_state_s s;
	dcc_state_s next_s;

	logic [4:0] addr;
	assign addr = AVS_ADDRESS[4:0];

	always_comb begin
		logic req;
		logic hit_cmd;
		logic rd_take;
		logic wr_take;
		logic wr_lane0;
		logic b_on;
		logic a_on;
		logic new_a;
		logic new_b;
		logic wake_en;
		logic wake_set;
		logic wake_clr;
		logic [DCC_IRQ_W-1:0] ev;
		logic [7:0] rd;
		req = 1'b0;
		hit_cmd = 1'b0;
		rd_take = 1'b0;
		wr_take = 1'b0;
		wr_lane0 = 1'b0;
		b_on = 1'b0;
		a_on = 1'b0;
		new_a = 1'b0;
		new_b = 1'b0;
		wake_en = 1'b0;
		wake_set = 1'b0;
		wake_clr = 1'b0;
		ev = '0;
		rd = 8'h00;
		next_s = s;

		// one wait cycle per access; effects fall on the released edge
		req = AVS_READ | AVS_WRITE;
		hit_cmd = req & s.waitreq;
		rd_take = AVS_READ & ~s.waitreq;
		wr_take = AVS_WRITE & ~s.waitreq;
		wr_lane0 = wr_take & AVS_BYTEENABLE[0];
		next_s.waitreq = ~hit_cmd;

		b_on = s.cmp_b_ctl[DCC_BIT_ON];
		a_on = s.cmp_a_ctl[DCC_BIT_ON];

		// raw is high when positive input is above negative
		// off comparator reads low: polarity only applies while on
		new_b = b_on & (CMP_B_RAW ^ ~s.cmp_b_ctl[DCC_BIT_POL]);
		new_a = a_on & (CMP_A_RAW ^ ~s.cmp_a_ctl[DCC_BIT_POL]);
		next_s.res_b = new_b;
		next_s.res_a = new_a;

		// analog steering; defaults while off leave the pins to others
		next_s.ana_b.on = b_on;
		next_s.ana_b.pos_sel = DCC_POS_B_NEG_PIN;
		next_s.ana_b.neg_pin = 1'b0;
		if (b_on) begin
			if (s.cmp_b_ctl[DCC_BIT_POS1])
				next_s.ana_b.pos_sel = DCC_POS_B_POS_PIN;
			else if (s.cmp_b_ctl[DCC_BIT_POS2])
				next_s.ana_b.pos_sel = DCC_POS_A_POS_PIN;
			else
				next_s.ana_b.pos_sel = DCC_POS_B_NEG_PIN;
			next_s.ana_b.neg_pin = s.cmp_b_ctl[DCC_BIT_NEG];
		end
		next_s.ana_a_on = a_on;

		// shared pin: timer input and direction rule unless B drives it
		next_s.pin_c4.out = PORT_C_PIN_FOUR_DATA;
		next_s.pin_c4.oe = ~TIMER_CLOCK_SOURCE_SELECT &
			~PIN_DIRECTION_CONTROL_C4;
		if (b_on & ~s.cmp_b_ctl[DCC_BIT_PIN_N]) begin
			next_s.pin_c4.out = s.res_b;
			next_s.pin_c4.oe = 1'b1;
		end

		// wake-on-change compares against the states caught at a read
		wake_en = (b_on & ~s.cmp_b_ctl[DCC_BIT_WAKE_N]) |
			(a_on & ~s.cmp_a_ctl[DCC_BIT_WAKE_N]);
		wake_set = wake_en & SLEEP &
			((s.res_a != s.lat_a) | (s.res_b != s.lat_b));
		wake_clr = DEV_RST;
		if (wr_lane0 && addr == DCC_OFS_STATUS &&
			!AVS_WRITEDATA[DCC_BIT_WAKE_FLAG])
			wake_clr = 1'b1;
		if (wake_set)
			next_s.wake = 1'b1;
		else if (wake_clr)
			next_s.wake = 1'b0;

		if (rd_take && (addr == DCC_OFS_CMP_B || addr == DCC_OFS_CMP_A)) begin
			next_s.lat_a = s.res_a;
			next_s.lat_b = s.res_b;
		end

		// register writes; result bit is not stored
		if (wr_lane0) begin
			unique case (addr)
			DCC_OFS_CMP_B: begin
				next_s.cmp_b_ctl[6:0] = AVS_WRITEDATA[6:0];
			end
			DCC_OFS_CMP_A: begin
				next_s.cmp_a_ctl[6:0] = AVS_WRITEDATA[6:0];
			end
			DCC_OFS_IRQ_MASK: begin
				next_s.irq_mask = AVS_WRITEDATA[DCC_IRQ_W-1:0];
			end
			default: begin
			end
			endcase
		end

		// read data prepared on the wait cycle
		unique case (addr)
		DCC_OFS_CMP_B: rd = {s.res_b, s.cmp_b_ctl[6:0]};
		DCC_OFS_CMP_A: rd = {s.res_a, s.cmp_a_ctl[6:0]};
		DCC_OFS_STATUS: rd = {1'b0, s.wake, 6'h00};
		DCC_OFS_IRQ_ST: rd = {5'h00, s.irq_st};
		DCC_OFS_IRQ_MASK: rd = {5'h00, s.irq_mask};
		default: rd = 8'h00;
		endcase
		if (hit_cmd && AVS_READ)
			next_s.rdata = {24'h000000, rd};

		// sticky events; a read clears them but a new event wins
		ev[DCC_IRQ_WAKE] = wake_set & ~s.wake;
		ev[DCC_IRQ_B_CHG] = new_b != s.res_b;
		ev[DCC_IRQ_A_CHG] = new_a != s.res_a;
		if (rd_take && addr == DCC_OFS_IRQ_ST)
			next_s.irq_st = ev;
		else
			next_s.irq_st = s.irq_st | ev;
		next_s.irq = |(next_s.irq_st & next_s.irq_mask);

		if (SRST) begin
			// power-on: controls to all ones, flag cleared
			next_s = '0;
			next_s.cmp_b_ctl = DCC_CTRL_RESET;
			next_s.cmp_a_ctl = DCC_CTRL_RESET;
			next_s.waitreq = 1'b1;
		end
	end

	always_ff @(posedge CLOCK) begin
		s <= next_s;
	end

	assign AVS_READDATA = s.rdata;
	assign AVS_WAITREQUEST = s.waitreq;
	assign IRQ = s.irq;
	assign PORT_C_PIN_FOUR_OUT = s.pin_c4.out;
	assign PORT_C_PIN_FOUR_OE = s.pin_c4.oe;
	assign CMP_B_ANALOG_ON = s.ana_b.on;
	assign CMP_B_POS_SELECT = s.ana_b.pos_sel;
	assign CMP_B_NEG_SELECT = s.ana_b.neg_pin;
	assign CMP_A_ANALOG_ON = s.ana_a_on;
endmodule
`default_nettype wire

/* File: tb/dcc_top_asserts.sv */
// port assertions of the comparator control block
`timescale 1ns/1ps
`default_nettype none
module dcc_top_asserts
	import dcc_pkg::*;
#(
	parameter int ADDR_W = 5
) (
	input wire logic CLOCK,
	input wire logic SRST,
	input wire logic [ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	input wire logic CMP_B_RAW,
	input wire logic TIMER_CLOCK_SOURCE_SELECT,
	input wire logic PORT_C_PIN_FOUR_OUT,
	input wire logic PORT_C_PIN_FOUR_OE,
	input wire logic CMP_B_ANALOG_ON,
	input wire logic [1:0] CMP_B_POS_SELECT,
	input wire logic CMP_B_NEG_SELECT
);
	logic [6:0] ctl;
	logic [1:0] age;
	wire logic hit = !AVS_WAITREQUEST && AVS_ADDRESS == DCC_OFS_CMP_B;
	wire logic wr = hit && AVS_WRITE && AVS_BYTEENABLE[0];
	// outputs trail a write, so judge them only once it has settled
	wire logic s = age == 2'h3;
	always_ff @(posedge CLOCK) begin
		age <= SRST || wr ? 2'h0 : age + {1'h0, !s};
		ctl <= SRST ? 7'h7F : wr ? AVS_WRITEDATA[6:0] : ctl;
	end
	default clocking @(posedge CLOCK); endclocking
	default disable iff (SRST);
	a_wait_one_cycle: assert property (
		(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
		|=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST) else $error("wait");
	a_enable_follows: assert property (
		s |-> CMP_B_ANALOG_ON == ctl[3]) else $error("enable");
	a_pos_select: assert property (
		s && ctl[3] |-> CMP_B_POS_SELECT == {ctl[1], ctl[1] | ctl[4]})
		else $error("pos select");
	a_neg_select: assert property (
		s && ctl[3] |-> CMP_B_NEG_SELECT == ctl[2]) else $error("neg select");
	a_off_idle: assert property (
		s && !ctl[3] |-> CMP_B_POS_SELECT == 2'h0 && !CMP_B_NEG_SELECT)
		else $error("select while off");
	a_pin_result: assert property (
		s && ctl[3] && !ctl[6] |-> PORT_C_PIN_FOUR_OE
		&& PORT_C_PIN_FOUR_OUT == ($past(CMP_B_RAW, 2) ~^ ctl[5]))
		else $error("pin result");
	a_pin_released: assert property (
		s && ctl[6] && $past(TIMER_CLOCK_SOURCE_SELECT) |-> !PORT_C_PIN_FOUR_OE)
		else $error("pin driven");
	a_read_control: assert property (
		AVS_READ && hit |-> AVS_READDATA == {24'h0, AVS_READDATA[7], ctl})
		else $error("control read");
endmodule
bind dcc_top dcc_top_asserts #(.ADDR_W(ADDR_W)) dcc_top_asserts_i (.*);
`default_nettype wire

/* File: tb/dcc_top_test.sv */
// self-checking bench of the comparator control block
`timescale 1ns/1ps
`default_nettype none
module dcc_top_test;
	import dcc_pkg::*;
	logic CLOCK = 1'h0, SRST = 1'h1, DEV_RST = 1'h0, SLEEP = 1'h0, IRQ;
	logic AVS_READ = 1'h0, AVS_WRITE = 1'h0, AVS_WAITREQUEST;
	logic CMP_A_RAW = 1'h0, CMP_B_RAW = 1'h0, CMP_A_ANALOG_ON;
	logic TIMER_CLOCK_SOURCE_SELECT = 1'h1, PIN_DIRECTION_CONTROL_C4 = 1'h1;
	logic PORT_C_PIN_FOUR_DATA = 1'h0, PORT_C_PIN_FOUR_OUT, PORT_C_PIN_FOUR_OE;
	logic CMP_B_ANALOG_ON, CMP_B_NEG_SELECT;
	logic [1:0] CMP_B_POS_SELECT;
	logic [3:0] AVS_BYTEENABLE = 4'hF;
	logic [4:0] AVS_ADDRESS = 5'h00;
	logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA;
	logic [7:0] expq[$];
	int failures = 0, checks = 0, seed = 32'h3B12185F;
	dcc_top dcc_top_i (.*);
	task automatic cmp(input string n, input logic [31:0] e, s);
		checks++;
		if (s !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic close_out;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// a read carries its expected value in d
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(posedge CLOCK);
		if (!w)
			expq.push_back(d);
		AVS_READ <= !w;
		AVS_WRITE <= w;
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= {24'h0, d};
		// hold everything until the edge that sees waitrequest low
		do
			@(posedge CLOCK);
		while (AVS_WAITREQUEST !== 1'h0);
		AVS_READ <= 1'h0;
		AVS_WRITE <= 1'h0;
	endtask
	task automatic irq_is(input logic e);
		repeat (4) @(negedge CLOCK);
		cmp("irq", {31'h0, e}, {31'h0, IRQ});
		@(posedge CLOCK);
	endtask
	always #10 CLOCK = ~CLOCK;
	always @(posedge CLOCK)
		{TIMER_CLOCK_SOURCE_SELECT, PIN_DIRECTION_CONTROL_C4,
			PORT_C_PIN_FOUR_DATA} <= 3'($random(seed));
	// read data stands at the edge that ends the request
	always @(posedge CLOCK)
		if (AVS_READ && AVS_WAITREQUEST === 1'h0)
			cmp("rdata", {24'h0, expq.pop_front()}, AVS_READDATA);
	initial begin
		#50000;
		failures++;
		close_out;
	end
	initial begin
		repeat (2) @(posedge CLOCK);
		SRST <= 1'h0;
		@(posedge CLOCK);
		bus(0, DCC_OFS_CMP_B, 8'h7F);
		bus(0, DCC_OFS_CMP_A, 8'h7F);
		bus(0, DCC_OFS_STATUS, 8'h00);
		bus(1, 5'h14, 8'h55);
		bus(0, 5'h14, 8'h00);
		$display("reset test done");
		CMP_B_RAW <= 1'h1;
		for (int i = 0; i < 8; i++) begin
			bus(1, DCC_OFS_CMP_B, {3'h1, i[2], 1'h1, i[1:0], 1'h0});
			bus(0, DCC_OFS_CMP_B, {3'h5, i[2], 1'h1, i[1:0], 1'h0});
		end
		bus(1, DCC_OFS_CMP_B, 8'h88);
		bus(0, DCC_OFS_CMP_B, 8'h08);
		bus(1, DCC_OFS_CMP_B, 8'hA0);
		bus(0, DCC_OFS_CMP_B, 8'h20);
		$display("control test done");
		bus(1, DCC_OFS_CMP_B, 8'h28);
		bus(0, DCC_OFS_CMP_B, 8'hA8);
		bus(0, DCC_OFS_IRQ_ST, 8'h02);
		bus(1, DCC_OFS_IRQ_MASK, 8'h01);
		SLEEP <= 1'h1;
		irq_is(1'h0);
		CMP_B_RAW <= 1'h0;
		irq_is(1'h1);
		bus(0, DCC_OFS_STATUS, 8'h40);
		bus(1, DCC_OFS_IRQ_MASK, 8'h00);
		irq_is(1'h0);
		SLEEP <= 1'h0;
		DEV_RST <= 1'h1;
		@(posedge CLOCK);
		DEV_RST <= 1'h0;
		// low byte lane off: the write must leave the control alone
		AVS_BYTEENABLE <= 4'hE;
		bus(1, DCC_OFS_CMP_B, 8'h00);
		AVS_BYTEENABLE <= 4'hF;
		bus(0, DCC_OFS_STATUS, 8'h00);
		bus(0, DCC_OFS_CMP_B, 8'h28);
		bus(0, DCC_OFS_IRQ_ST, 8'h03);
		bus(1, DCC_OFS_IRQ_MASK, 8'h07);
		irq_is(1'h0);
		$display("wake test done");
		cmp("a on", 32'h1, {31'h0, CMP_A_ANALOG_ON});
		CMP_A_RAW <= 1'h1;
		bus(0, DCC_OFS_CMP_A, 8'hFF);
		bus(0, DCC_OFS_IRQ_ST, 8'h04);
		bus(1, DCC_OFS_CMP_A, 8'h00);
		repeat (2) @(posedge CLOCK);
		cmp("a on", 32'h0, {31'h0, CMP_A_ANALOG_ON});
		$display("first comparator test done");
		close_out;
	end
endmodule
`default_nettype wire
